/* hdl/rbp_host_port.sv */
/*
  rtc host bus port: strobe decode, address latch, time snapshot, tick hold-off,
  prescaler, control registers and interrupt status.
  assumes an outside counter block that applies cnt_advance and cnt_wr_* and reports cnt_event.
*/
`timescale 1ns/1ps
`default_nettype none
module rbp_host_port
  import rbp_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    rd_n,
  input  wire logic                    wr_n,
  input  wire logic                    cs_n,
  input  wire logic                    ale,
  input  wire logic [rbp_pkg::ADDR_W-1:0] addr,
  input  wire logic [rbp_pkg::DATA_W-1:0] data_in,
  output var  logic [rbp_pkg::DATA_W-1:0] data_out,
  output logic                         data_oe,
  input  wire logic                    crystal_in,
  input  wire logic [rbp_pkg::DATA_W-1:0] cnt_hundredths,
  input  wire logic [rbp_pkg::SNAP_W-1:0] cnt_time,
  input  wire logic [rbp_pkg::FLAG_W-1:0] cnt_event,
  output var  logic                    cnt_advance,
  output var  logic                    cnt_wr,
  output var  logic [rbp_pkg::CIDX_W-1:0] cnt_wr_addr,
  output var  logic [rbp_pkg::DATA_W-1:0] cnt_wr_data,
  output var  logic                    irq_drive
);
  import rbp_pkg::*;

  logic [PIN_W-1:0]  pins_s;
  logic              rd_act;
  logic              wr_act;
  logic              cs_n_s;
  logic              ale_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] din_s;
  logic              xtal_s;
  logic              xtal_prev;
  logic [ADDR_W-1:0] lat_addr;
  logic              lat_cs_n;
  logic [ADDR_W-1:0] acc_addr;
  logic              sel;
  rbp_state_t        state;
  rbp_state_t        next_state;
  logic              st_read;
  logic              rd_start;
  logic              rd_end;
  logic              wr_end;
  logic [SNAP_W-1:0] snapshot;
  logic [DATA_W-1:0] snap_word [NUM_CNT];
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] cmd;
  logic [DATA_W-1:0] mask;
  logic [FLAG_W-1:0] status_flags;
  logic              global_flag;
  logic              stat_clr;
  logic              hit;
  logic              xtal_edge;
  logic [ACC_W-1:0]  acc;
  logic [ACC_W-1:0]  acc_sum;
  logic [ACC_W-1:0]  xtal_hz;
  logic              tick4k;
  logic [DIV_W-1:0]  div100;
  logic              tick100;
  logic              tick_req;
  logic              pending;
  logic              next_advance;
  logic              wr_cnt;

  // strobes sampled active low
  rbp_pin_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) rbp_pin_sync_i (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin     ({crystal_in, data_in, addr, ale, cs_n, wr_n, rd_n}),
    .q       (pins_s)
  );
  assign rd_act = ~pins_s[0];
  assign wr_act = ~pins_s[1];
  assign cs_n_s = pins_s[2];
  assign ale_s  = pins_s[3];
  assign addr_s = pins_s[8:4];
  assign din_s  = pins_s[16:9];
  assign xtal_s = pins_s[17];

  // ale high is transparent, falling ale holds address and select
  assign acc_addr = ale_s ? addr_s : lat_addr;
  // a grounded select leaves the strobes alone in charge
  assign sel      = ~(ale_s ? cs_n_s : lat_cs_n);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sel && rd_act) begin
          next_state = ST_READ;
        end else if (sel && wr_act) begin
          next_state = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_act) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_act) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign st_read  = (state == ST_READ);
  assign rd_start = (state == ST_IDLE) && sel && rd_act;
  assign rd_end   = st_read && !rd_act;
  // data taken at the end of the strobe, when the host bus is surely settled
  assign wr_end   = (state == ST_WRITE) && !wr_act;
  assign wr_cnt   = wr_end && rbp_is_cnt(acc_addr);
  assign stat_clr = rd_end && (acc_addr == ADDR_IRQ);

  // live hundredths, the others from the snapshot
  assign snap_word[0] = cnt_hundredths;
  genvar i;
  for (i = 1; i < NUM_CNT; i++) begin : g_field
    assign snap_word[i] = DATA_W'(snapshot[CNT_LSB[i] +: CNT_W[i]]);
  end
  assign rd_word = rbp_is_cnt(acc_addr) ? snap_word[acc_addr[CIDX_W-1:0]] :
                   (acc_addr == ADDR_IRQ) ? {global_flag, status_flags} : BYTE_ZERO;
  // bus driven only while a selected read is under way
  assign data_oe = st_read;

  // fractional divider, so the 4000 hz tick jitters but averages true
  assign xtal_edge = xtal_s && !xtal_prev;
  assign xtal_hz   = rbp_xtal_hz(cmd[CMD_FSEL +: 2]);
  assign acc_sum   = acc + TICK4K_HZ;
  assign tick4k    = xtal_edge && (acc_sum >= xtal_hz);
  assign tick100   = tick4k && (div100 == DIV100_LAST);
  // test mode feeds raw oscillator edges run bit gates
  assign tick_req  = cmd[CMD_RUN] && (cmd[CMD_TEST] ? xtal_edge : tick100);
  // hold off during reads, one pending tick at most
  assign next_advance = !st_read && (tick_req || pending);

  // an event meeting its mask with the enable bit turns the output on
  assign hit = cmd[CMD_IEN] && |(cnt_event & mask[FLAG_W-1:0]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      lat_addr  <= ADDR_HUND;
      lat_cs_n  <= PIN_RST[2];
      xtal_prev <= PIN_RST[17];
      data_out  <= BYTE_ZERO;
    end else begin
      state     <= next_state;
      xtal_prev <= xtal_s;
      data_out  <= rd_word;
      if (ale_s) begin
        lat_addr <= addr_s;
        lat_cs_n <= cs_n_s;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      snapshot <= SNAP_RST;
    end else if (rd_start && acc_addr == ADDR_HUND) begin
      snapshot <= cnt_time;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd  <= CMD_RST;
      mask <= MASK_RST;
    end else if (wr_end && acc_addr == ADDR_CMD) begin
      cmd  <= din_s;
    end else if (wr_end && acc_addr == ADDR_IRQ) begin
      mask <= din_s;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_wr      <= 1'b0;
      cnt_wr_addr <= ADDR_HUND[CIDX_W-1:0];
      cnt_wr_data <= BYTE_ZERO;
    end else begin
      cnt_wr <= wr_cnt;
      if (wr_cnt) begin
        cnt_wr_addr <= acc_addr[CIDX_W-1:0];
        cnt_wr_data <= din_s;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc         <= ACC_RST;
      div100      <= DIV_RST;
      pending     <= 1'b0;
      cnt_advance <= 1'b0;
    end else begin
      cnt_advance <= next_advance;
      pending     <= st_read && (pending || tick_req);
      if (xtal_edge) begin
        acc <= tick4k ? acc_sum - xtal_hz : acc_sum;
      end
      if (tick4k) begin
        div100 <= (div100 == DIV100_LAST) ? DIV_RST : div100 + DIV_W'(1'b1);
      end
    end
  end

  // new events win over the clearing read, so none is lost
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_flags <= FLAG_RST;
      global_flag  <= 1'b0;
      irq_drive    <= 1'b0;
    end else begin
      status_flags <= (status_flags & ~{FLAG_W{stat_clr}}) | cnt_event;
      global_flag  <= hit || (global_flag && !stat_clr);
      irq_drive    <= hit || (irq_drive && !stat_clr);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_hund_read;
    rd_start && acc_addr == ADDR_HUND;
  endsequence
  sequence s_release;
    pending && !st_read;
  endsequence

  a_store_on_hund: assert property (s_hund_read |=> snapshot == $past(cnt_time))
    else $error("snapshot not stored on hundredths read");
  a_tick_held_read: assert property (st_read |=> !cnt_advance)
    else $error("counter advanced during a read");
  a_tick_released: assert property (s_release |=> cnt_advance ##0 !pending)
    else $error("postponed tick not released once");
  a_snap_stable: assert property (!rd_start |=> $stable(snapshot))
    else $error("snapshot changed without hundredths read");
  a_no_accum: assert property (st_read && pending && tick_req |=> !st_read || pending)
    else $error("pending tick lost during long read");
  a_bus_drive: assert property (rd_start |=> data_oe)
    else $error("data bus not driven on selected read");
  a_bus_release: assert property (state == ST_IDLE && !sel |=> !data_oe)
    else $error("data bus driven while deselected");
  a_one_release: assert property (s_release |=> ##1 (!cnt_advance || $past(tick_req)))
    else $error("held ticks accumulated after read");
  a_cmd_write: assert property (wr_end && acc_addr == ADDR_CMD |=> cmd == $past(din_s))
    else $error("command register not loaded");
  a_mask_zero: assert property (mask == MASK_RST && !irq_drive |=> !irq_drive)
    else $error("interrupt with all sources masked");
  a_run_gate: assert property (!cmd[CMD_RUN] && !pending |=> !cnt_advance)
    else $error("counter advanced while stopped");
  a_test_tick: assert property (cmd[CMD_TEST] && cmd[CMD_RUN] && xtal_edge && !st_read |=> cnt_advance)
    else $error("test mode did not pass oscillator edge");
  a_irq_set: assert property (hit |=> irq_drive && global_flag)
    else $error("interrupt or global flag not set");
  a_irq_clear: assert property (stat_clr && !hit |=> !irq_drive ##1 (!irq_drive || $past(hit)))
    else $error("status read did not release interrupt");
  a_latch_hold: assert property (!ale_s |=> $stable(lat_addr) && $stable(lat_cs_n))
    else $error("address latch moved with ale low");
  a_live_hund: assert property (st_read && acc_addr == ADDR_HUND |=> data_out == $past(cnt_hundredths))
    else $error("hundredths read not live");
endmodule
`default_nettype wire

/* inc/rbp_pkg.sv */
/*
  shared constants, register map and types of the rtc host bus port.
  assumes the counter block outside packs its live time as the snapshot layout below.
*/
package rbp_pkg;
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int SNAP_W  = 36;
  localparam int FLAG_W  = 7;
  localparam int NUM_CNT = 8;
  localparam int CIDX_W  = 3;
  localparam int ACC_W   = 23;
  localparam int DIV_W   = 6;
  localparam int PIN_W   = 18;

  localparam logic [ADDR_W-1:0] ADDR_HUND     = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LAST = 5'h07;
  localparam logic [ADDR_W-1:0] ADDR_IRQ      = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_CMD      = 5'h11;

  localparam int CMD_FSEL    = 0;
  localparam int CMD_RUN     = 3;
  localparam int CMD_IEN     = 4;
  localparam int CMD_TEST    = 5;
  localparam int STAT_GLOBAL = 7;

  localparam logic [DATA_W-1:0] CMD_RST   = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RST  = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RST  = 7'h00;
  localparam logic [SNAP_W-1:0] SNAP_RST  = 36'h000000000;

  // pin bundle {crystal_in, data[7:0], addr[4:0], ale, cs_n, wr_n, rd_n}; strobes idle high
  localparam logic [PIN_W-1:0] PIN_RST = 18'h0000f;

  // fractional divider down to the 4000 hz tick, then by 40 to 100 hz
  localparam logic [ACC_W-1:0] TICK4K_HZ   = 23'h000fa0;
  localparam logic [ACC_W-1:0] ACC_RST     = 23'h000000;
  localparam logic [DIV_W-1:0] DIV100_LAST = 6'h27;
  localparam logic [DIV_W-1:0] DIV_RST     = 6'h00;

  // counter widths and snapshot positions, index = counter address
  localparam int CNT_W   [NUM_CNT] = '{8, 6, 6, 5, 3, 5, 4, 7};
  localparam int CNT_LSB [NUM_CNT] = '{0, 0, 6, 12, 17, 20, 25, 29};

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } rbp_state_t;

  function automatic logic [ACC_W-1:0] rbp_xtal_hz(input logic [1:0] sel);
    case (sel)
      2'h0:    rbp_xtal_hz = 23'h008000;
      2'h1:    rbp_xtal_hz = 23'h100000;
      2'h2:    rbp_xtal_hz = 23'h200000;
      default: rbp_xtal_hz = 23'h400000;
    endcase
  endfunction

  function automatic logic rbp_is_cnt(input logic [ADDR_W-1:0] a);
    rbp_is_cnt = (a <= ADDR_CNT_LAST);
  endfunction
endpackage

/* hdl/rbp_pin_sync.sv */
/*
  three-flop synchroniser for a bundle of pins, with a two-of-two agreement filter.
  assumes the pins are asynchronous to clk_sys and slower than a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rbp_pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // a bit moves only once the second and third stages agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    assign next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q  <= RST_VAL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule
`default_nettype wire

/* testbench/rbp_host_model.sv */
/*
  host cpu model driving the rtc port pins, direct or multiplexed addressing.
  assumes the bench clock; pins change just after rising edges only.
*/
`timescale 1ns/1ps
`default_nettype none
module rbp_host_model (
  input  wire logic                       clk_sys,
  input  wire logic [rbp_pkg::DATA_W-1:0] data_out,
  input  wire logic                       data_oe,
  output var  logic                       rd_n,
  output var  logic                       wr_n,
  output var  logic                       cs_n,
  output var  logic                       ale,
  output var  logic [rbp_pkg::ADDR_W-1:0] addr,
  output wire logic [rbp_pkg::DATA_W-1:0] data_in
);
  import rbp_pkg::*;
  logic [DATA_W-1:0] hval;
  logic              hdrv;
  // released bus shows the port's data while it drives, else the inverse of the last value, never a stale copy
  assign data_in = hdrv ? hval : (data_oe ? data_out : ~hval);
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    cs_n = 1'b0;
    ale  = 1'b1;
    addr = '0;
    hval = '0;
    hdrv = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // waits for the port to drive, holds, then samples once
  task automatic rd(input logic [ADDR_W-1:0] a, input logic c, input int hold,
                    output logic [DATA_W-1:0] d, output logic s);
    int i;
    cyc(1);
    addr <= a;
    cs_n <= c;
    cyc(1);
    rd_n <= 1'b0;
    s = 1'b0;
    d = '0;
    for (i = 0; i < 20 && data_oe !== 1'b1; i++) begin
      cyc(1);
    end
    if (data_oe === 1'b1) begin
      cyc(2 + hold);
      d = data_out;
      s = 1'b1;
    end
    rd_n <= 1'b1;
    cyc(8);
    cs_n <= 1'b0;
    ale  <= 1'b1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    cyc(1);
    addr <= a;
    hval <= v;
    hdrv <= 1'b1;
    cyc(1);
    wr_n <= 1'b0;
    cyc(8);
    wr_n <= 1'b1;
    cyc(8);
    hdrv <= 1'b0;
  endtask
  // multiplexed cycle: address shown, ale falls, lines then carry other data
  task automatic latch(input logic [ADDR_W-1:0] a, input logic c);
    cyc(1);
    addr <= a;
    cs_n <= c;
    cyc(6);
    ale <= 1'b0;
    cyc(6);
    addr <= ~a;
  endtask
endmodule
`default_nettype wire

/* testbench/rbp_host_port_test.sv */
/*
  self-checking bench for the rtc host bus port.
  assumes rbp_host_model on the pins; the bench plays the counter block.
*/
`timescale 1ns/1ps
`default_nettype none
module rbp_host_port_test;
  import rbp_pkg::*;
  logic              clk_sys;
  logic              nrst;
  logic              crystal_in;
  logic [DATA_W-1:0] cnt_hundredths;
  logic [SNAP_W-1:0] cnt_time;
  logic [FLAG_W-1:0] cnt_event;
  wire               rd_n, wr_n, cs_n, ale, data_oe, cnt_advance, cnt_wr, irq_drive;
  wire  [ADDR_W-1:0] addr;
  wire  [DATA_W-1:0] data_in, data_out, cnt_wr_data;
  wire  [CIDX_W-1:0] cnt_wr_addr;
  logic [CIDX_W-1:0] wa = '0;
  logic [DATA_W-1:0] wd = '0;
  int                adv = 0, nwr = 0, xc = 0, n_fail = 0, total_checks = 0;

  rbp_host_port rbp_host_port_i (.clk_sys(clk_sys), .nrst(nrst), .rd_n(rd_n), .wr_n(wr_n),
    .cs_n(cs_n), .ale(ale), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .crystal_in(crystal_in), .cnt_hundredths(cnt_hundredths),
    .cnt_time(cnt_time), .cnt_event(cnt_event), .cnt_advance(cnt_advance), .cnt_wr(cnt_wr),
    .cnt_wr_addr(cnt_wr_addr), .cnt_wr_data(cnt_wr_data), .irq_drive(irq_drive));
  rbp_host_model host_i (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe),
    .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .ale(ale), .addr(addr), .data_in(data_in));

  always #2 clk_sys = ~clk_sys;
  // crystal at a tenth of clk_sys, slow enough for the pin filter
  always @(posedge clk_sys) begin
    xc <= (xc == 4) ? 0 : xc + 1;
    if (xc == 4) begin
      crystal_in <= ~crystal_in;
    end
    if (cnt_advance === 1'b1) begin
      adv <= adv + 1;
    end
    if (cnt_wr === 1'b1) begin
      nwr <= nwr + 1;
      wa  <= cnt_wr_addr;
      wd  <= cnt_wr_data;
    end
  end

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    logic              s;
    host_i.rd(a, 1'b0, 0, d, s);
    chk("read data", {1'b1, e}, {s, d});
  endtask
  task automatic ev(input logic [FLAG_W-1:0] v);
    cnt_event <= v;
    host_i.cyc(1);
    cnt_event <= '0;
    host_i.cyc(3);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic t_snap;
    logic [SNAP_W-1:0] ta;
    ta = 36'h123456789;
    cnt_time <= ta;
    cnt_hundredths <= 8'h5a;
    rc(ADDR_HUND, 8'h5a);
    cnt_time <= ~ta;
    cnt_hundredths <= 8'h11;
    rc(5'h01, {2'h0, ta[5:0]});
    rc(5'h07, {1'h0, ta[35:29]});
    rc(ADDR_HUND, 8'h11);
    rc(5'h01, {2'h0, ~ta[5:0]});
    $display("done snapshot");
  endtask
  task automatic t_bus;
    logic [DATA_W-1:0] d;
    logic              s;
    int                n0;
    rc(5'h09, 8'h00);
    rc(ADDR_CMD, 8'h00);
    host_i.rd(ADDR_HUND, 1'b1, 0, d, s);
    chk("deselected read", 1'b0, s);
    n0 = nwr;
    host_i.wr(5'h03, 8'h17);
    chk("counter write", {8'h01, 3'h3, 8'h17}, {8'(nwr - n0), wa, wd});
    host_i.latch(ADDR_HUND, 1'b0);
    rc(5'h01, 8'h11);
    host_i.latch(ADDR_HUND, 1'b1);
    host_i.rd(ADDR_HUND, 1'b0, 0, d, s);
    chk("latched deselect", 1'b0, s);
    $display("done bus");
  endtask
  task automatic t_irq;
    host_i.wr(ADDR_IRQ, 8'h00);
    host_i.wr(ADDR_CMD, 8'h18);
    ev(7'h08);
    chk("masked irq", 1'b0, irq_drive);
    rc(ADDR_IRQ, 8'h08);
    host_i.wr(ADDR_IRQ, 8'h08);
    ev(7'h04);
    chk("tenths irq", 1'b0, irq_drive);
    ev(7'h08);
    chk("second irq", 1'b1, irq_drive);
    rc(ADDR_IRQ, 8'h8c);
    chk("irq release", 1'b0, irq_drive);
    ev(7'h08);
    chk("irq rearm", 1'b1, irq_drive);
    rc(ADDR_IRQ, 8'h88);
    host_i.wr(ADDR_CMD, 8'h08);
    ev(7'h08);
    chk("disabled irq", 1'b0, irq_drive);
    rc(ADDR_IRQ, 8'h08);
    $display("done irq");
  endtask
  task automatic t_tick;
    logic [DATA_W-1:0] d;
    logic              s;
    int                a0;
    host_i.wr(ADDR_CMD, 8'h28);
    a0 = adv;
    host_i.cyc(200);
    chk("test mode ticks", 1'b1, adv - a0 >= 19 && adv - a0 <= 21);
    a0 = adv;
    host_i.rd(ADDR_HUND, 1'b0, 150, d, s);
    chk("long read ticks", 1'b1, adv - a0 >= 1 && adv - a0 <= 3);
    host_i.wr(ADDR_CMD, 8'h20);
    a0 = adv;
    host_i.cyc(200);
    chk("stopped ticks", 0, adv - a0);
    nrst <= 1'b0;
    host_i.cyc(2);
    nrst <= 1'b1;
    host_i.cyc(4);
    rc(5'h01, 8'h00);
    host_i.wr(ADDR_CMD, 8'h08);
    a0 = adv;
    host_i.cyc(5000);
    chk("prescaled ticks", 1, adv - a0);
    $display("done ticks");
  endtask

  initial begin
    clk_sys        = 1'b0;
    nrst           = 1'b0;
    crystal_in     = 1'b0;
    cnt_hundredths = 8'h00;
    cnt_time       = '0;
    cnt_event      = '0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    host_i.cyc(4);
    t_snap();
    t_bus();
    t_irq();
    t_tick();
    end_sim();
  end
  // about six thousand cycles expected; cut off well beyond
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
